// ===== src/counter_start_trigger_select.sv
// Function
// R01: started counter counts up from zero, stops at the count limit
// R02: with source off, counter begins only on software reset command
// R03: acquisition start and end events can begin the counter
// R04: exposure start/end, general and per-channel blue red green nir, can begin
// R05: action events one and two can begin the counter
// R06: general input lines one to four begin it, rising edge by default
// R07: general output lines three to six begin it, rising edge by default
// R08: shaft position encoder event can begin the counter
// R09: valid frame begin event can begin the counter
// R10: rejected frame trigger event can begin the counter
// R11: valid row begin event can begin the counter
// R12: rejected row trigger event can begin the counter
// R13: end of timer one or timer two can begin the counter
// R14: end of counter one or two can begin, allowing chaining
// R15: edge setting applies only to line sources, ignored otherwise
// R16: rising edge setting begins on low-to-high line transition
// R17: falling edge setting begins on high-to-low line transition
// R18: either edge setting begins on any line transition
// R19: two counters; selector picks which one the settings address
// R20: software reconfigures a counter only while it is disabled
// R21: state reads idle, awaiting, running, done or wrapped
// R22: begin events honoured only while active and awaiting begin
// R23: lines synchronised before edge detection, one pulse per edge
`timescale 1ns/1ps
`include "cstart_defines.svh"
module counter_start_trigger_select #(
  parameter int W = 16
) (
  input  wire logic                       clk,                // device clock
  input  wire logic                       rst,                // synchronous reset, high

  // settings written by software
  input  wire logic                       whichCounterSelect, // 0 first, 1 second
  input  wire logic                       cfgWrite,           // settings write strobe
  input  wire logic [`BEGIN_SEL_W-1:0]    beginSelectIn,      // begin source code
  input  wire logic [`EDGE_SEL_W-1:0]     edgeSelectIn,       // begin edge code
  input  wire logic [W-1:0]               limitIn,            // count limit
  input  wire logic                       enableIn,           // active setting

  // software command and increment events
  input  wire logic                       counterResetCmd,    // reset command pulse
  input  wire logic [1:0]                 incTick,            // increment events

  // one-cycle event pulses from the timing logic
  input  wire logic                       acqStart,           // acquisition start
  input  wire logic                       acqEnd,             // acquisition end
  input  wire logic                       expStart,           // exposure start
  input  wire logic                       expEnd,             // exposure end
  // per-channel exposure pulses
  input  wire logic [3:0]                 expStartCh,         // b r g nir start
  input  wire logic [3:0]                 expEndCh,           // b r g nir end
  input  wire logic [1:0]                 actionEvent,        // action one, two

  // raw line levels, synchronised inside
  input  wire logic [3:0]                 generalInputPin,    // input lines 1..4
  input  wire logic [3:0]                 generalOutputPin,   // output lines 3..6

  // further event pulses
  input  wire logic                       shaftPositionInput, // encoder event
  input  wire logic                       frameBeginEvent,    // valid frame begin
  input  wire logic                       rejectedFrameEvent, // rejected frame
  input  wire logic                       rowBeginEvent,      // valid row begin
  input  wire logic                       rejectedRowEvent,   // rejected row
  input  wire logic [1:0]                 timerDone,          // timer one, two end

  // status, every one straight from a flop
  output cstart_pkg::counting_state_e     countingState,      // selected state
  output cstart_pkg::counting_state_e     stateFirst,         // first counter state
  output cstart_pkg::counting_state_e     stateSecond,        // second counter state
  output logic      [W-1:0]               valueFirst,         // first count
  output logic      [W-1:0]               valueSecond,        // second count
  output logic                            doneFirst,          // first end pulse
  output logic                            doneSecond          // second end pulse
);

  // settings of both counters and the state view
  typedef struct packed {
    logic [1:0]                         enable;
    logic [1:0][`BEGIN_SEL_W-1:0]       beginSel;
    logic [1:0][`EDGE_SEL_W-1:0]        edgeSel;
    logic [1:0][W-1:0]                  limit;
    // registered copy of the selected state
    cstart_pkg::counting_state_e        stateSel;
  } top_s;

  top_s                        q;
  top_s                        next_q;

  // decode results; line edges and end pulses come from flops
  logic [`EVENT_TOTAL-1:0]     evVec;
  logic [`LINE_TOTAL-1:0]      lineRise;
  logic [`LINE_TOTAL-1:0]      lineFall;
  logic [1:0]                  beginPulse;
  logic [1:0]                  beginIsOff;
  logic [1:0]                  resetCmd;
  logic [1:0]                  endPulse;

  //////////////////////////////////////////////////////////////////
  // pick the begin event for one counter
  function automatic logic beginEvent(
    input logic [`BEGIN_SEL_W-1:0] sel,
    input logic [`EDGE_SEL_W-1:0]  edgeSel,
    input logic [`EVENT_TOTAL-1:0] ev,
    input logic [`LINE_TOTAL-1:0]  rise,
    input logic [`LINE_TOTAL-1:0]  fall
  );
    // scratch for the line index and result
    logic [2:0] idx;
    logic       hit;

    // line index, meaningful for line codes only
    idx = 3'(sel - `SEL_FIRST_LINE);
    // plain events pick their own bit
    hit = ev[sel];

    // R15: edge only for lines
    if (sel >= `SEL_FIRST_LINE && sel <= `SEL_LAST_LINE) begin
      case (edgeSel)
        // R17: falling edge
        `EDGE_DOWN: begin
          hit = fall[idx];
        end

        // R18: either edge
        `EDGE_EITHER: begin
          hit = rise[idx] | fall[idx];
        end

        // R16: rising edge
        // code 3 is unused and counts as rising
        default: begin
          hit = rise[idx];
        end
      endcase
    end

    return hit;
  endfunction

  //////////////////////////////////////////////////////////////////
  // line synchroniser and edge detectors
  // R06: input lines
  // R07: output lines
  // a line high at reset release gives one rise
  // outputs sit above inputs in the line vector
  line_edge_sync #(
    .N (`LINE_TOTAL)
  ) u_lines (
    .clk       (clk),
    .rst       (rst),
    .lineIn    ({generalOutputPin, generalInputPin}),
    .risePulse (lineRise),
    .fallPulse (lineFall)
  );

  //////////////////////////////////////////////////////////////////
  // event vector indexed by begin source code
  always_comb begin
    // unused bits stay low
    evVec                    = '0;
    // code zero never fires, off waits for the command
    evVec[`SEL_OFF]          = 1'b0;

    // R03: acquisition events
    evVec[`SEL_ACQ_START]    = acqStart;
    evVec[`SEL_ACQ_END]      = acqEnd;

    // R04: exposure events
    // channel order blue, red, green, nir
    evVec[`SEL_EXP_START]    = expStart;
    evVec[`SEL_EXP_END]      = expEnd;
    evVec[`SEL_EXP_START_B]  = expStartCh[0];
    evVec[`SEL_EXP_START_R]  = expStartCh[1];
    evVec[`SEL_EXP_START_G]  = expStartCh[2];
    evVec[`SEL_EXP_START_N]  = expStartCh[3];
    evVec[`SEL_EXP_END_B]    = expEndCh[0];
    evVec[`SEL_EXP_END_R]    = expEndCh[1];
    evVec[`SEL_EXP_END_G]    = expEndCh[2];
    evVec[`SEL_EXP_END_N]    = expEndCh[3];

    // R05: action events
    evVec[`SEL_ACTION_ONE]   = actionEvent[0];
    evVec[`SEL_ACTION_TWO]   = actionEvent[1];

    // R08: shaft encoder
    evVec[`SEL_SHAFT]        = shaftPositionInput;

    // R09: frame begin
    evVec[`SEL_FRAME_BEGIN]  = frameBeginEvent;

    // R10: rejected frame
    evVec[`SEL_FRAME_REJECT] = rejectedFrameEvent;

    // R11: row begin
    evVec[`SEL_ROW_BEGIN]    = rowBeginEvent;

    // R12: rejected row
    evVec[`SEL_ROW_REJECT]   = rejectedRowEvent;

    // R13: timer end events
    evVec[`SEL_TIMER_ONE]    = timerDone[0];
    evVec[`SEL_TIMER_TWO]    = timerDone[1];

    // R14: counter chaining
    // end pulses come from flops, so no loop
    evVec[`SEL_COUNT_ONE]    = endPulse[0];
    evVec[`SEL_COUNT_TWO]    = endPulse[1];
  end

  //////////////////////////////////////////////////////////////////
  // per counter begin pulse, off flag and reset command
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      beginPulse[i] = beginEvent(q.beginSel[i], q.edgeSel[i], evVec, lineRise, lineFall);
      // off means only the command begins
      beginIsOff[i] = (q.beginSel[i] == `SEL_OFF);

      // R19: command goes to the selected counter
      resetCmd[i]   = counterResetCmd & (whichCounterSelect == 1'(i));
    end
  end

  //////////////////////////////////////////////////////////////////
  // settings and selected state register
  always_comb begin
    next_q = q;

    for (int i = 0; i < 2; i++) begin
      // R19: selector addresses one counter
      if (cfgWrite && whichCounterSelect == 1'(i)) begin
        // enable always taken, so a busy counter can stop
        next_q.enable[i] = enableIn;

        // R20: settings taken only while disabled
        if (!q.enable[i]) begin
          next_q.beginSel[i] = beginSelectIn;
          next_q.edgeSel[i]  = edgeSelectIn;
          next_q.limit[i]    = limitIn;
        end
      end
    end

    // R21: readable state of selected counter
    // view trails the selector by one cycle
    next_q.stateSel = whichCounterSelect ? stateSecond : stateFirst;
  end

  // settings register
  always_ff @(posedge clk) begin
    if (rst) begin
      // disabled, source off, rising edge, limit zero
      q.enable   <= {2{`RST_ENABLE}};
      q.beginSel <= {2{`RST_SEL}};
      q.edgeSel  <= {2{`RST_EDGE}};
      q.limit    <= '0;
      q.stateSel <= cstart_pkg::COUNTING_IDLE;
    end else begin
      q <= next_q;
    end
  end

  //////////////////////////////////////////////////////////////////
  // the two counters
  // first counter, its end is begin code 1E
  count_unit #(
    .W (W)
  ) u_first (
    .clk        (clk),
    .rst        (rst),
    .enable     (q.enable[0]),
    .beginIsOff (beginIsOff[0]),
    .beginPulse (beginPulse[0]),
    .resetCmd   (resetCmd[0]),
    .incTick    (incTick[0]),
    .limit      (q.limit[0]),
    .state      (stateFirst),
    .value      (valueFirst),
    .endPulse   (endPulse[0])
  );

  // second counter, wired the same way
  count_unit #(
    .W (W)
  ) u_second (
    .clk        (clk),
    .rst        (rst),
    .enable     (q.enable[1]),
    .beginIsOff (beginIsOff[1]),
    .beginPulse (beginPulse[1]),
    .resetCmd   (resetCmd[1]),
    .incTick    (incTick[1]),
    .limit      (q.limit[1]),
    .state      (stateSecond),
    .value      (valueSecond),
    .endPulse   (endPulse[1])
  );

  // outputs, all from flip-flops
  // no logic between these flops and the pins
  assign countingState = q.stateSel;
  assign doneFirst     = endPulse[0];
  assign doneSecond    = endPulse[1];

endmodule // counter_start_trigger_select

// ===== src/cstart_defines.svh
`ifndef CSTART_DEFINES_SVH
`define CSTART_DEFINES_SVH

// widths of the selection fields, the line vector and the event vector
`define BEGIN_SEL_W      5
`define EDGE_SEL_W       2
`define LINE_TOTAL       8
`define EVENT_TOTAL      32

// begin source codes, also the bit positions in the event vector
`define SEL_OFF          5'h00
`define SEL_ACQ_START    5'h01
`define SEL_ACQ_END      5'h02
`define SEL_EXP_START    5'h03
`define SEL_EXP_END      5'h04
`define SEL_EXP_START_B  5'h05
`define SEL_EXP_START_R  5'h06
`define SEL_EXP_START_G  5'h07
`define SEL_EXP_START_N  5'h08
`define SEL_EXP_END_B    5'h09
`define SEL_EXP_END_R    5'h0A
`define SEL_EXP_END_G    5'h0B
`define SEL_EXP_END_N    5'h0C
`define SEL_ACTION_ONE   5'h0D
`define SEL_ACTION_TWO   5'h0E
`define SEL_FIRST_LINE   5'h0F
`define SEL_LAST_LINE    5'h16
`define SEL_SHAFT        5'h17
`define SEL_FRAME_BEGIN  5'h18
`define SEL_FRAME_REJECT 5'h19
`define SEL_ROW_BEGIN    5'h1A
`define SEL_ROW_REJECT   5'h1B
`define SEL_TIMER_ONE    5'h1C
`define SEL_TIMER_TWO    5'h1D
`define SEL_COUNT_ONE    5'h1E
`define SEL_COUNT_TWO    5'h1F

// edge selection codes
`define EDGE_UP          2'h0
`define EDGE_DOWN        2'h1
`define EDGE_EITHER      2'h2

// reset values of the settings
`define RST_SEL          `SEL_OFF
`define RST_EDGE         `EDGE_UP
`define RST_ENABLE       1'h0

`endif

// ===== src/cstart_pkg.sv
package cstart_pkg;

  // one-hot counter state as software reads it
  typedef enum logic [4:0] {
    COUNTING_IDLE    = 5'h01,
    AWAITING_BEGIN   = 5'h02,
    COUNTING_RUNNING = 5'h04,
    COUNTING_DONE    = 5'h08,
    COUNTING_WRAPPED = 5'h10
  } counting_state_e;

endpackage

// ===== src/line_edge_sync.sv
`timescale 1ns/1ps
module line_edge_sync #(
  parameter int N = 8
) (
  input  wire logic         clk,       // device clock
  input  wire logic         rst,       // synchronous reset, high
  input  wire logic [N-1:0] lineIn,    // raw line levels
  output logic      [N-1:0] risePulse, // one-cycle rise pulses
  output logic      [N-1:0] fallPulse  // one-cycle fall pulses
);

  typedef struct packed {
    logic [N-1:0] syncA;
    logic [N-1:0] syncB;
    logic [N-1:0] prev;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
  } sync_s;

  sync_s q;
  sync_s next_q;

  //////////////////////////////////////////////////////////////////
  // two-stage sync then edge compare on the second stage
  // R23: sync and edge pulse
  always_comb begin
    next_q       = q;
    next_q.syncA = lineIn;
    next_q.syncB = q.syncA;
    next_q.prev  = q.syncB;
    next_q.rise  = q.syncB & ~q.prev;
    next_q.fall  = ~q.syncB & q.prev;
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign risePulse = q.rise;
  assign fallPulse = q.fall;

endmodule // line_edge_sync

// ===== src/count_unit.sv
`timescale 1ns/1ps
module count_unit #(
  parameter int W = 16
) (
  input  wire logic                       clk,        // device clock
  input  wire logic                       rst,        // synchronous reset, high
  input  wire logic                       enable,     // counter active setting
  input  wire logic                       beginIsOff, // begin source is off
  input  wire logic                       beginPulse, // chosen begin event
  input  wire logic                       resetCmd,   // software reset command
  input  wire logic                       incTick,    // increment event
  input  wire logic [W-1:0]               limit,      // count limit
  output cstart_pkg::counting_state_e     state,      // counter state
  output logic      [W-1:0]               value,      // current count
  output logic                            endPulse    // one-cycle end event
);

  typedef struct packed {
    cstart_pkg::counting_state_e st;
    logic [W-1:0]                cnt;
    logic                        endP;
  } unit_s;

  unit_s q;
  unit_s next_q;

  //////////////////////////////////////////////////////////////////
  // counter state machine
  always_comb begin
    next_q      = q;
    next_q.endP = 1'b0;
    if (!enable) begin
      next_q.st  = cstart_pkg::COUNTING_IDLE;
      next_q.cnt = '0;
    end else if (resetCmd) begin
      // R02: reset command begins
      next_q.cnt = '0;
      next_q.st  = beginIsOff ? cstart_pkg::COUNTING_RUNNING : cstart_pkg::AWAITING_BEGIN;
    end else begin
      case (q.st)
        cstart_pkg::COUNTING_IDLE: begin
          if (!beginIsOff) begin
            next_q.st = cstart_pkg::AWAITING_BEGIN;
          end
        end
        cstart_pkg::AWAITING_BEGIN: begin
          // R22: honoured only here
          if (beginIsOff) begin
            next_q.st = cstart_pkg::COUNTING_IDLE;
          end else if (beginPulse) begin
            next_q.cnt = '0;
            next_q.st  = cstart_pkg::COUNTING_RUNNING;
          end
        end
        cstart_pkg::COUNTING_RUNNING: begin
          // R01: count up to limit
          if (q.cnt == limit) begin
            next_q.st   = cstart_pkg::COUNTING_DONE;
            next_q.endP = 1'b1;
          end else if (incTick) begin
            // R21: wrapped at maximum
            if (&q.cnt) begin
              next_q.st = cstart_pkg::COUNTING_WRAPPED;
            end else begin
              next_q.cnt = W'(q.cnt + 1'b1);
            end
          end
        end
        cstart_pkg::COUNTING_DONE,
        cstart_pkg::COUNTING_WRAPPED: begin
          next_q.st = q.st; // hold until reset or disable
        end
        default: begin
          next_q.st = cstart_pkg::COUNTING_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{st: cstart_pkg::COUNTING_IDLE, cnt: '0, endP: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign state    = q.st;
  assign value    = q.cnt;
  assign endPulse = q.endP;

endmodule // count_unit

// ===== dv/event_source_model.sv
`timescale 1ns/1ps
// far-side model: one-cycle event pulses and held line levels
module event_source_model (
  input  wire logic        clk,  // device clock
  input  wire logic        fire, // raise one event
  input  wire logic [4:0]  code, // source code to raise
  input  wire logic        lvl,  // new level for line codes
  output logic      [31:0] ev    // event vector, lines at 0f..16
);
  logic [31:0] pulse = '0;
  logic [7:0]  line  = '0;
  ////////////////////////////////////////////////////////////
  // pulses last one cycle, lines keep their level
  always_ff @(posedge clk) begin
    pulse <= '0;
    if (fire && (code < 5'h0F || code > 5'h16)) pulse[code] <= 1'b1;
    if (fire && code >= 5'h0F && code <= 5'h16) line[code - 5'h0F] <= lvl;
  end
  // lines overlay the pulse vector
  always_comb begin
    ev        = pulse;
    ev[22:15] = line;
  end
endmodule // event_source_model

// ===== dv/counter_start_trigger_select_properties.sv
`timescale 1ns/1ps
module counter_start_trigger_select_properties #(
  parameter int W = 16
) (
  input wire logic                   clk,                // device clock
  input wire logic                   rst,                // sync reset
  input wire logic                   whichCounterSelect, // counter pick
  input wire logic                   cfgWrite,           // settings write
  input wire logic                   enableIn,           // active setting
  input wire logic                   counterResetCmd,    // reset command
  input wire logic [1:0]             incTick,            // increments
  input cstart_pkg::counting_state_e countingState,      // selected state
  input cstart_pkg::counting_state_e stateFirst,         // first state
  input cstart_pkg::counting_state_e stateSecond,        // second state
  input wire logic [W-1:0]           valueFirst,         // first count
  input wire logic                   doneFirst           // first end pulse
);
  localparam cstart_pkg::counting_state_e RUN = cstart_pkg::COUNTING_RUNNING;
  localparam cstart_pkg::counting_state_e WAIT = cstart_pkg::AWAITING_BEGIN;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // state encoding
  one_hot_state_a: assert property ($onehot(stateFirst) && $onehot(stateSecond))
    else $error("state not one-hot");
  // end pulse shape and cause
  done_single_cycle_a: assert property (doneFirst |=> !doneFirst)
    else $error("end pulse longer than one cycle");
  done_with_state_a: assert property (doneFirst |-> stateFirst == cstart_pkg::COUNTING_DONE)
    else $error("end pulse without done state");
  done_from_running_a: assert property ($rose(doneFirst) |-> $past(stateFirst) == RUN)
    else $error("end pulse not preceded by counting");
  // counting from zero in steps of one
  begin_at_zero_a: assert property (stateFirst == WAIT ##1 stateFirst == RUN |-> valueFirst == '0)
    else $error("count did not begin at zero");
  hold_without_tick_a: assert property ((stateFirst == RUN && !incTick[0] && !cfgWrite
    && !counterResetCmd) |=> $stable(valueFirst)) else $error("count moved without tick");
  step_by_one_a: assert property ((stateFirst == RUN && incTick[0] && !cfgWrite
    && !counterResetCmd) ##1 stateFirst == RUN |-> valueFirst == $past(valueFirst) + W'(1))
    else $error("count step not one");
  // reset command restarts an enabled counter
  reset_cmd_a: assert property ((counterResetCmd && !whichCounterSelect && !cfgWrite
    && stateFirst != cstart_pkg::COUNTING_IDLE && !$past(cfgWrite)) |=> valueFirst == '0
    && (stateFirst == RUN || stateFirst == WAIT)) else $error("reset command ignored");
  // disable returns to idle
  off_goes_idle_a: assert property (cfgWrite && !enableIn && !whichCounterSelect
    |-> ##2 stateFirst == cstart_pkg::COUNTING_IDLE) else $error("disable did not idle");
  // selected state view
  view_follows_select_a: assert property (!$past(rst)
    |-> countingState == $past(whichCounterSelect ? stateSecond : stateFirst))
    else $error("selected state view wrong");
endmodule // counter_start_trigger_select_properties

bind counter_start_trigger_select counter_start_trigger_select_properties #(.W(W)) props (
  .clk(clk), .rst(rst), .whichCounterSelect(whichCounterSelect), .cfgWrite(cfgWrite),
  .enableIn(enableIn), .counterResetCmd(counterResetCmd), .incTick(incTick),
  .countingState(countingState), .stateFirst(stateFirst), .stateSecond(stateSecond),
  .valueFirst(valueFirst), .doneFirst(doneFirst));

// ===== dv/counter_start_trigger_select_tb.sv
`timescale 1ns/1ps
module counter_start_trigger_select_tb;
  localparam int W = 4;
  logic                        clk, rst, whichCounterSelect, cfgWrite, enableIn;
  logic                        counterResetCmd, fire, lvl, doneFirst, doneSecond;
  logic [4:0]                  beginSelectIn, code;
  logic [1:0]                  edgeSelectIn, incTick;
  logic [W-1:0]                limitIn, valueFirst, valueSecond;
  logic [31:0]                 ev;
  cstart_pkg::counting_state_e countingState, stateFirst, stateSecond;
  int                          mismatches, compares, p;

  event_source_model src (.clk(clk), .fire(fire), .code(code), .lvl(lvl), .ev(ev));
  counter_start_trigger_select #(.W(W)) dut (
    .clk(clk), .rst(rst), .whichCounterSelect(whichCounterSelect), .cfgWrite(cfgWrite),
    .beginSelectIn(beginSelectIn), .edgeSelectIn(edgeSelectIn), .limitIn(limitIn),
    .enableIn(enableIn), .counterResetCmd(counterResetCmd), .incTick(incTick),
    .acqStart(ev[1]), .acqEnd(ev[2]), .expStart(ev[3]), .expEnd(ev[4]),
    .expStartCh(ev[8:5]), .expEndCh(ev[12:9]), .actionEvent(ev[14:13]),
    .generalInputPin(ev[18:15]), .generalOutputPin(ev[22:19]), .shaftPositionInput(ev[23]),
    .frameBeginEvent(ev[24]), .rejectedFrameEvent(ev[25]), .rowBeginEvent(ev[26]),
    .rejectedRowEvent(ev[27]), .timerDone(ev[29:28]), .countingState(countingState),
    .stateFirst(stateFirst), .stateSecond(stateSecond), .valueFirst(valueFirst),
    .valueSecond(valueSecond), .doneFirst(doneFirst), .doneSecond(doneSecond));

  ////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // compare and count
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // let n edges pass, then settle
  task automatic wait_cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one settings write
  task automatic cfg(logic w, logic [4:0] s, logic [1:0] e, logic [W-1:0] l, logic en);
    @(posedge clk) whichCounterSelect <= w;
    beginSelectIn      <= s;
    edgeSelectIn       <= e;
    limitIn            <= l;
    enableIn           <= en;
    cfgWrite           <= 1'b1;
    @(posedge clk) cfgWrite <= 1'b0;
  endtask
  // one far-side event or line level
  task automatic raise(logic [4:0] c, logic l);
    @(posedge clk) fire <= 1'b1;
    code <= c;
    lvl  <= l;
    @(posedge clk) fire <= 1'b0;
  endtask
  // software reset command pulse
  task automatic reset_pulse();
    @(posedge clk) counterResetCmd <= 1'b1;
    @(posedge clk) counterResetCmd <= 1'b0;
    #1;
  endtask
  // verdict
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst, whichCounterSelect, cfgWrite, enableIn, counterResetCmd, fire, lvl} = 7'h40;
    {beginSelectIn, code, edgeSelectIn, incTick, limitIn} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset state", stateFirst, cstart_pkg::COUNTING_IDLE);
    chk("reset value", valueFirst, '0);
    // every pulse source except the lines and the counter ends, edge setting ignored
    for (int c = 1; c < 30; c++) begin
      if (c >= 15 && c <= 22) continue;
      cfg(1'b0, c[4:0], 2'h1, '0, 1'b1);
      wait_cyc(2);
      raise(c == 1 ? 5'h02 : 5'h01, 1'b0);
      wait_cyc(4);
      chk("other event", stateFirst, cstart_pkg::AWAITING_BEGIN);
      raise(c[4:0], 1'b0);
      wait_cyc(4);
      chk("event start", stateFirst, cstart_pkg::COUNTING_DONE);
      cfg(1'b0, 5'h00, 2'h0, '0, 1'b0);
    end
    // each line with each edge code
    for (int c = 15; c <= 22; c++) begin
      for (int e = 0; e < 4; e++) begin
        p = (e == 0 || e == 3);
        raise(c[4:0], p[0]);
        wait_cyc(6);
        cfg(1'b0, c[4:0], e[1:0], '0, 1'b1);
        wait_cyc(2);
        if (e != 2) begin
          raise(c[4:0], !p[0]);
          wait_cyc(8);
          chk("wrong edge", stateFirst, cstart_pkg::AWAITING_BEGIN);
        end
        raise(c[4:0], e == 2 ? !p[0] : p[0]);
        wait_cyc(8);
        chk("line start", stateFirst, cstart_pkg::COUNTING_DONE);
        cfg(1'b0, 5'h00, 2'h0, '0, 1'b0);
      end
    end
    // source off waits for the reset command
    cfg(1'b0, 5'h00, 2'h0, 4'h2, 1'b1);
    wait_cyc(3);
    chk("off idle", stateFirst, cstart_pkg::COUNTING_IDLE);
    cfg(1'b1, 5'h1E, 2'h0, 4'h1, 1'b1);
    wait_cyc(2);
    chk("chain wait", stateSecond, cstart_pkg::AWAITING_BEGIN);
    @(posedge clk) whichCounterSelect <= 1'b0;
    reset_pulse();
    chk("cmd start", stateFirst, cstart_pkg::COUNTING_RUNNING);
    chk("start zero", valueFirst, '0);
    // two ticks to the limit, then the end pulse
    @(posedge clk);
    incTick <= 2'h1;
    repeat (2) @(posedge clk);
    incTick <= 2'h0;
    #1;
    chk("count two", valueFirst, 4'h2);
    wait_cyc(1);
    chk("end pulse", doneFirst, 1'b1);
    chk("done state", stateFirst, cstart_pkg::COUNTING_DONE);
    wait_cyc(1);
    chk("end once", doneFirst, 1'b0);
    chk("chained", stateSecond, cstart_pkg::COUNTING_RUNNING);
    // settings written while active are dropped
    cfg(1'b0, 5'h01, 2'h0, 4'h2, 1'b1);
    reset_pulse();
    chk("kept source", stateFirst, cstart_pkg::COUNTING_RUNNING);
    @(posedge clk);
    {whichCounterSelect, incTick} <= 3'h6;
    @(posedge clk) incTick <= 2'h0;
    wait_cyc(1);
    chk("second end", {doneSecond, valueSecond}, 5'h11);
    wait_cyc(2);
    chk("view second", countingState, cstart_pkg::COUNTING_DONE);
    report_and_stop();
  end
endmodule // counter_start_trigger_select_tb
